// [src/btxe_pkg.sv]
// Shared constants for the burst transmit front end
package btxe_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          CHIP_IDX_W    = 6;
  localparam int          CNT_W         = 16;
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CHIP_DIV  = 8'h04;
  localparam logic [7:0]  OFS_DATA_CHIPS = 8'h08;
  localparam logic [7:0]  OFS_ACQ_CHIPS = 8'h0C;
  localparam logic [7:0]  OFS_BURST_LEN = 8'h10;
  localparam logic [7:0]  OFS_DCODE_LO  = 8'h14;
  localparam logic [7:0]  OFS_DCODE_HI  = 8'h18;
  localparam logic [7:0]  OFS_ACODE_LO  = 8'h1C;
  localparam logic [7:0]  OFS_ACODE_HI  = 8'h20;
  localparam logic [7:0]  OFS_STATUS    = 8'h24;
  // Control bit positions
  localparam int          CTRL_TX_EN    = 0;
  localparam int          CTRL_SW_START = 1;
  localparam int          CTRL_QPSK     = 2;
  localparam int          CTRL_CONT     = 3;
  localparam int          CTRL_EXT_CHIP = 4;
  localparam int          CTRL_W        = 5;
  // Status bit positions
  localparam int          STAT_ACTIVE   = 16;
  localparam int          STAT_PRE      = 17;
  // Reset values and burst length limit
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [15:0] CHIP_DIV_RST  = 16'h0003;
  localparam logic [5:0]  CHIPS_RST     = 6'h0B;
  localparam logic [15:0] BURST_RST     = 16'h0010;
  localparam logic [15:0] BURST_MAX     = 16'hFFFD;
  // Bit fetch sequence steps
  localparam logic [2:0]  FS_REQ_A      = 3'h0;
  localparam logic [2:0]  FS_TAKE_A     = 3'h2;
  localparam logic [2:0]  FS_TAKE_B     = 3'h4;
  typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_SYM, ST_FETCH} btxe_state_e;
endpackage

// [src/btxe_chip_div.sv]
// Programmable chip rate divider
`timescale 1ns/1ps
module btxe_chip_div #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic         run,
  input  wire logic [W-1:0] div,
  output logic              tick
);
  logic [W-1:0] cnt_r;

  // Count clocks per chip, idle when powered down
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      if (!run)
      begin
        cnt_r <= '0;
        tick  <= 1'b0;
      end
      else if (cnt_r >= div)
      begin
        cnt_r <= '0;
        tick  <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
        tick  <= 1'b0;
      end
    end
  end
endmodule // btxe_chip_div

// [src/btxe_diff_enc.sv]
// Differential DBPSK / DQPSK encoder
`timescale 1ns/1ps
module btxe_diff_enc (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic load,
  input  wire logic qpsk,
  input  wire logic din_i,
  input  wire logic din_q,
  output logic      enc_i,
  output logic      enc_q
);
  // Position of a dibit on the 00,01,11,10 cycle
  function automatic logic [1:0] step_of(input logic [1:0] g);
    case (g)
      2'h0:    step_of = 2'h0;
      2'h1:    step_of = 2'h1;
      2'h3:    step_of = 2'h2;
      default: step_of = 2'h3;
    endcase
  endfunction

  function automatic logic [1:0] dibit_of(input logic [1:0] s);
    dibit_of = {s[1], s[1] ^ s[0]};
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      enc_i <= 1'b0;
      enc_q <= 1'b0;
    end
    else if (ce)
    begin
      if (clear)
      begin
        enc_i <= 1'b0;
        enc_q <= 1'b0;
      end
      else if (load && qpsk)
        {enc_i, enc_q} <= dibit_of(step_of({din_i, din_q}) +
                                   step_of({enc_i, enc_q}));
      else if (load)
      begin
        enc_i <= din_i ^ enc_i;
        enc_q <= din_i ^ enc_i;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_dbpsk_xor: assert property (ce && load && !clear && !qpsk |=>
    enc_i == ($past(din_i) ^ $past(enc_i)) && enc_q == enc_i)
    else $error("dbpsk encode wrong");
  a_dqpsk_hold: assert property (ce && load && !clear && qpsk &&
    !din_i && !din_q |=> {enc_i, enc_q} == $past({enc_i, enc_q}))
    else $error("dqpsk 00 did not hold");
  a_dqpsk_two: assert property (ce && load && !clear && qpsk &&
    din_i && din_q |=> {enc_i, enc_q} == ~$past({enc_i, enc_q}))
    else $error("dqpsk 11 did not advance two steps");
endmodule // btxe_diff_enc

// [src/btxe_top.sv]
// Burst transmit input processor, timing and differential encoder
`timescale 1ns/1ps
// Behaviour
// - Burst mode sends programmed symbol count automatically, up to 65,533.
// - Continuous mode never ends the burst on its own.
// - One preamble symbol precedes data, own PN code, same chip rate.
// - Programmable 16-bit symbol counter stops transmission at burst end.
// - Programmable divider gives chip and symbol rate timing.
// - Symbol period is chips per symbol plus at least one idle chip period between symbols.
// - Optionally take chip timing from external reference; host supplies it.
// - Transmit timing runs apart from any receive timing.
// - QPSK packs two serial bits into an I,Q dibit per symbol.
// - Serial data enters one bit at a time; host presents each bit.
// - BPSK requests exactly one bit per symbol.
// - QPSK requests two bits per symbol.
// - All data is differentially encoded before spreading.
// - DBPSK output is input XOR previous output.
// - DQPSK advances 0,1,2,3 steps on cycle 00,01,11,10 by dibit.
// - Transmitter powers down independently, no switching.
// - Rising start input or software start begins with preamble symbol.
// - Pulse preamble done, then request data bits.
// - Encoded bits XOR PN code, one full code per symbol.
module btxe_top #(
  parameter int DIV_W = 16
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic                          ce,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [btxe_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [btxe_pkg::DATA_W-1:0]   pwdata,
  output logic      [btxe_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          tx_start_input,
  input  wire logic                          tx_serial_in,
  input  wire logic                          tx_ext_chip_ref,
  output logic                               tx_bit_request,
  output logic                               preamble_done_pulse,
  output logic                               spread_i_out,
  output logic                               spread_q_out,
  output logic                               tx_active
);
  generate
    if (DIV_W < 2 || DIV_W > btxe_pkg::CNT_W)
    begin : g_bad_div
      $error("DIV_W out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [btxe_pkg::CTRL_W-1:0]     ctrl_r;
  logic [DIV_W-1:0]                chip_div_r;
  logic [btxe_pkg::CHIP_IDX_W-1:0] data_chips_r;
  logic [btxe_pkg::CHIP_IDX_W-1:0] acq_chips_r;
  logic [btxe_pkg::CNT_W-1:0]      burst_len_r;
  logic [63:0]                     dcode_r;
  logic [63:0]                     acode_r;
  logic                            wr_fire;
  btxe_pkg::btxe_state_e           st_r;
  logic                            pre_r;
  logic [btxe_pkg::CNT_W-1:0]      sym_left_r;
  logic [btxe_pkg::CHIP_IDX_W:0]   chip_cnt_r;
  logic [2:0]                      fstep_r;
  logic                            bit_i_r;
  logic                            start_prev_r;
  logic                            sw_prev_r;
  logic                            ext_prev_r;
  logic                            div_tick;
  logic                            chip_tick;
  logic                            start_evt;
  logic                            enc_i;
  logic                            enc_q;
  logic                            enc_load;
  logic                            enc_clear;
  logic                            pn_bit;
  logic [btxe_pkg::CHIP_IDX_W:0]   sym_len;
  logic [2:0]                      fetch_last;
  logic                            tx_en;
  logic                            qpsk;
  logic                            cont;
  logic                            ext_sel;

  assign tx_en   = ctrl_r[btxe_pkg::CTRL_TX_EN];
  assign qpsk    = ctrl_r[btxe_pkg::CTRL_QPSK];
  assign cont    = ctrl_r[btxe_pkg::CTRL_CONT];
  assign ext_sel = ctrl_r[btxe_pkg::CTRL_EXT_CHIP];

  function automatic logic addr_ok(input logic [btxe_pkg::ADDR_W-1:0] a);
    addr_ok = (a <= btxe_pkg::OFS_STATUS) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [btxe_pkg::DATA_W-1:0] rd_mux(
    input logic [btxe_pkg::ADDR_W-1:0] a);
    rd_mux = '0;
    if (a == btxe_pkg::OFS_CTRL)
      rd_mux[btxe_pkg::CTRL_W-1:0] = ctrl_r;
    else if (a == btxe_pkg::OFS_CHIP_DIV)
      rd_mux[DIV_W-1:0] = chip_div_r;
    else if (a == btxe_pkg::OFS_DATA_CHIPS)
      rd_mux[btxe_pkg::CHIP_IDX_W-1:0] = data_chips_r;
    else if (a == btxe_pkg::OFS_ACQ_CHIPS)
      rd_mux[btxe_pkg::CHIP_IDX_W-1:0] = acq_chips_r;
    else if (a == btxe_pkg::OFS_BURST_LEN)
      rd_mux[btxe_pkg::CNT_W-1:0] = burst_len_r;
    else if (a == btxe_pkg::OFS_DCODE_LO)
      rd_mux = dcode_r[31:0];
    else if (a == btxe_pkg::OFS_DCODE_HI)
      rd_mux = dcode_r[63:32];
    else if (a == btxe_pkg::OFS_ACODE_LO)
      rd_mux = acode_r[31:0];
    else if (a == btxe_pkg::OFS_ACODE_HI)
      rd_mux = acode_r[63:32];
    else if (a == btxe_pkg::OFS_STATUS)
    begin
      rd_mux[btxe_pkg::CNT_W-1:0]      = sym_left_r;
      rd_mux[btxe_pkg::STAT_ACTIVE]    = (st_r != btxe_pkg::ST_IDLE);
      rd_mux[btxe_pkg::STAT_PRE]       = pre_r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase
  assign wr_fire = psel && penable && pready && pwrite && addr_ok(paddr);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (ce)
    begin
      if (psel && !penable && !pready)
      begin
        pready  <= 1'b1;
        pslverr <= !addr_ok(paddr);
        prdata  <= (pwrite || !addr_ok(paddr)) ? '0 : rd_mux(paddr);
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r       <= btxe_pkg::CTRL_RST;
      chip_div_r   <= DIV_W'(btxe_pkg::CHIP_DIV_RST);
      data_chips_r <= btxe_pkg::CHIPS_RST;
      acq_chips_r  <= btxe_pkg::CHIPS_RST;
      burst_len_r  <= btxe_pkg::BURST_RST;
      dcode_r      <= '0;
      acode_r      <= '0;
    end
    else if (ce && wr_fire)
    begin
      if (paddr == btxe_pkg::OFS_CTRL)
        ctrl_r <= pwdata[btxe_pkg::CTRL_W-1:0];
      else if (paddr == btxe_pkg::OFS_CHIP_DIV)
        chip_div_r <= pwdata[DIV_W-1:0];
      else if (paddr == btxe_pkg::OFS_DATA_CHIPS)
        data_chips_r <= pwdata[btxe_pkg::CHIP_IDX_W-1:0];
      else if (paddr == btxe_pkg::OFS_ACQ_CHIPS)
        acq_chips_r <= pwdata[btxe_pkg::CHIP_IDX_W-1:0];
      else if (paddr == btxe_pkg::OFS_BURST_LEN)
        burst_len_r <= (pwdata[15:0] > btxe_pkg::BURST_MAX) ?
                       btxe_pkg::BURST_MAX : pwdata[15:0];
      else if (paddr == btxe_pkg::OFS_DCODE_LO)
        dcode_r[31:0] <= pwdata;
      else if (paddr == btxe_pkg::OFS_DCODE_HI)
        dcode_r[63:32] <= pwdata;
      else if (paddr == btxe_pkg::OFS_ACODE_LO)
        acode_r[31:0] <= pwdata;
      else if (paddr == btxe_pkg::OFS_ACODE_HI)
        acode_r[63:32] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip timing, internal divider or external reference
  btxe_chip_div #(.W(DIV_W)) u_div (
    .clk    (core_clk),
    .arst_n (arst_n),
    .ce     (ce),
    .run    (tx_en && !ext_sel),
    .div    (chip_div_r),
    .tick   (div_tick)
  );

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_prev_r   <= 1'b0;
      start_prev_r <= 1'b0;
      sw_prev_r    <= 1'b0;
    end
    else if (ce)
    begin
      ext_prev_r   <= tx_ext_chip_ref;
      start_prev_r <= tx_start_input;
      sw_prev_r    <= ctrl_r[btxe_pkg::CTRL_SW_START];
    end
  end

  assign chip_tick = ext_sel ? (tx_ext_chip_ref && !ext_prev_r)
                             : div_tick;
  assign start_evt = (tx_start_input && !start_prev_r) ||
                     (ctrl_r[btxe_pkg::CTRL_SW_START] && !sw_prev_r);

  // Chips per symbol, zero meaning the full 64
  assign sym_len = pre_r ? {acq_chips_r == '0, acq_chips_r}
                         : {data_chips_r == '0, data_chips_r};
  assign pn_bit  = pre_r ? acode_r[chip_cnt_r[btxe_pkg::CHIP_IDX_W-1:0]]
                         : dcode_r[chip_cnt_r[btxe_pkg::CHIP_IDX_W-1:0]];
  assign fetch_last = qpsk ? btxe_pkg::FS_TAKE_B : btxe_pkg::FS_TAKE_A;

  ////////////////////////////////////////////////////////////////////////////
  // Input processor and encoder
  assign enc_load  = (st_r == btxe_pkg::ST_FETCH) && (fstep_r == fetch_last);
  assign enc_clear = (st_r == btxe_pkg::ST_IDLE);

  btxe_diff_enc u_enc (
    .clk    (core_clk),
    .arst_n (arst_n),
    .ce     (ce),
    .clear  (enc_clear),
    .load   (enc_load),
    .qpsk   (qpsk),
    .din_i  (qpsk ? bit_i_r : tx_serial_in),
    .din_q  (tx_serial_in),
    .enc_i  (enc_i),
    .enc_q  (enc_q)
  );

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_bit_request <= 1'b0;
      bit_i_r        <= 1'b0;
      fstep_r        <= '0;
    end
    else if (ce)
    begin
      tx_bit_request <= (st_r == btxe_pkg::ST_FETCH) &&
                        (fstep_r == btxe_pkg::FS_REQ_A ||
                        (qpsk && fstep_r == btxe_pkg::FS_TAKE_A));
      if (st_r == btxe_pkg::ST_FETCH && fstep_r == btxe_pkg::FS_TAKE_A)
        bit_i_r <= tx_serial_in;
      fstep_r <= (st_r == btxe_pkg::ST_FETCH) ? fstep_r + 3'h1 : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r                <= btxe_pkg::ST_IDLE;
      pre_r               <= 1'b0;
      sym_left_r          <= '0;
      chip_cnt_r          <= '0;
      preamble_done_pulse <= 1'b0;
      spread_i_out        <= 1'b0;
      spread_q_out        <= 1'b0;
      tx_active           <= 1'b0;
    end
    else if (ce)
    begin
      preamble_done_pulse <= 1'b0;
      if (!tx_en)
      begin
        st_r         <= btxe_pkg::ST_IDLE;
        pre_r        <= 1'b0;
        spread_i_out <= 1'b0;
        spread_q_out <= 1'b0;
        tx_active    <= 1'b0;
      end
      else
      begin
        case (st_r)
          btxe_pkg::ST_IDLE:
            if (start_evt)
            begin
              st_r       <= btxe_pkg::ST_ALIGN;
              pre_r      <= 1'b1;
              sym_left_r <= burst_len_r;
            end
          btxe_pkg::ST_ALIGN:
            if (chip_tick)
            begin
              st_r         <= btxe_pkg::ST_SYM;
              chip_cnt_r   <= 7'h01;
              spread_i_out <= enc_i ^ pn_bit;
              spread_q_out <= enc_q ^ pn_bit;
              tx_active    <= 1'b1;
            end
          btxe_pkg::ST_SYM:
            if (chip_tick && chip_cnt_r == sym_len)
            begin
              spread_i_out <= 1'b0;
              spread_q_out <= 1'b0;
              tx_active    <= 1'b0;
              chip_cnt_r   <= '0;
              pre_r        <= 1'b0;
              if (pre_r)
                preamble_done_pulse <= 1'b1;
              else if (!cont)
                sym_left_r <= sym_left_r - 16'h0001;
              if (!cont && (pre_r ? sym_left_r == '0
                                  : sym_left_r <= 16'h0001))
                st_r <= btxe_pkg::ST_IDLE;
              else
                st_r <= btxe_pkg::ST_FETCH;
            end
            else if (chip_tick)
            begin
              chip_cnt_r   <= chip_cnt_r + 7'h01;
              spread_i_out <= enc_i ^ pn_bit;
              spread_q_out <= enc_q ^ pn_bit;
            end
          btxe_pkg::ST_FETCH:
            if (enc_load)
              st_r <= btxe_pkg::ST_ALIGN;
          default:
            st_r <= btxe_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [1:0] req_seen_r;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_seen_r <= '0;
    else if (ce && st_r == btxe_pkg::ST_SYM)
      req_seen_r <= '0;
    else if (ce && tx_bit_request)
      req_seen_r <= req_seen_r + 2'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_bpsk_one_req: assert property (ce && st_r == btxe_pkg::ST_ALIGN &&
    !pre_r && !qpsk |-> req_seen_r == 2'h1)
    else $error("bpsk symbol not one request");
  a_qpsk_two_req: assert property (ce && st_r == btxe_pkg::ST_ALIGN &&
    !pre_r && qpsk |-> req_seen_r == 2'h2)
    else $error("qpsk symbol not two requests");
  a_start_pre: assert property (ce && tx_en && st_r == btxe_pkg::ST_IDLE &&
    start_evt |=> st_r == btxe_pkg::ST_ALIGN && pre_r)
    else $error("start did not begin preamble");
  a_no_req_pre: assert property (tx_bit_request |-> !pre_r)
    else $error("bit requested during preamble");
  a_done_fetch: assert property (ce && preamble_done_pulse && tx_en |->
    st_r inside {btxe_pkg::ST_FETCH, btxe_pkg::ST_IDLE} ##0
    !$past(preamble_done_pulse))
    else $error("preamble done pulse misplaced");
  a_enc_cleared: assert property (st_r == btxe_pkg::ST_ALIGN && pre_r |->
    !enc_i && !enc_q)
    else $error("encoder not cleared at burst start");
  a_bpsk_same: assert property (!qpsk && tx_active |->
    spread_i_out == spread_q_out)
    else $error("bpsk i and q differ");
  a_cont_runs: assert property (ce && cont && tx_en &&
    st_r == btxe_pkg::ST_SYM |=> st_r != btxe_pkg::ST_IDLE || !tx_en)
    else $error("continuous burst ended");
  a_burst_end: assert property (ce && tx_en && !cont && !pre_r &&
    st_r == btxe_pkg::ST_SYM && chip_tick && chip_cnt_r == sym_len &&
    sym_left_r == 16'h0001 |=> st_r == btxe_pkg::ST_IDLE && !tx_active)
    else $error("burst did not stop at count");
  a_chip_spread: assert property (ce && tx_en && st_r == btxe_pkg::ST_SYM &&
    chip_tick && chip_cnt_r != sym_len |=>
    spread_i_out == ($past(enc_i) ^ $past(pn_bit)))
    else $error("spread chip wrong");
  a_power_down: assert property (ce && !tx_en |=>
    st_r == btxe_pkg::ST_IDLE && !tx_active && !spread_i_out)
    else $error("transmitter active while powered down");

  c_preamble: cover property (preamble_done_pulse);
  c_burst_end: cover property (st_r == btxe_pkg::ST_SYM && !cont ##1
    st_r == btxe_pkg::ST_IDLE);
  c_qpsk_sym: cover property (qpsk && enc_load);
  c_ext_chip: cover property (ext_sel && chip_tick && tx_active);
endmodule // btxe_top

// [verif/btxe_host_src.sv]
// Host serial data source for the transmit front end
`timescale 1ns/1ps
module btxe_host_src #(
  parameter logic [15:0] PAT = 16'hB4D2
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic tx_bit_request,
  output logic      tx_serial_in
);
  logic [3:0] idx_r;
  // One pattern bit per request, held one cycle, then toggled
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idx_r        <= 4'h0;
      tx_serial_in <= 1'b0;
    end
    else if (tx_bit_request)
    begin
      tx_serial_in <= PAT[idx_r];
      idx_r        <= idx_r + 4'h1;
    end
    else
    begin
      tx_serial_in <= ~tx_serial_in;
    end
  end
endmodule // btxe_host_src

// [verif/burst_tx_input_diff_encoder_test.sv]
// Testbench for the burst transmit front end
`timescale 1ns/1ps
module burst_tx_input_diff_encoder_test;
  logic        core_clk = 1'b0;
  logic        arst_n   = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        start    = 1'b0;
  logic        req_d    = 1'b0;
  logic        act_d    = 1'b0;
  logic        ext      = 1'b0;
  logic        ext_run  = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sin, breq, pdone, si, sq, act;
  int          num_errors = 0;
  int          n_compared = 0;
  int          npre, early;
  logic        bits_q[$];
  logic [1:0]  sym_q[$];
  always #10 core_clk = ~core_clk;
  btxe_top uut (.core_clk(core_clk), .arst_n(arst_n), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_start_input(start), .tx_serial_in(sin), .tx_ext_chip_ref(ext),
    .tx_bit_request(breq), .preamble_done_pulse(pdone),
    .spread_i_out(si), .spread_q_out(sq), .tx_active(act));
  btxe_host_src host (.core_clk(core_clk), .arst_n(arst_n),
    .tx_bit_request(breq), .tx_serial_in(sin));
  ////////////////////////////////////////////////////////////////////////
  // Monitor: fetched bits, preamble pulses, first chip of each symbol
  always @(posedge core_clk)
  begin
    if (req_d)
      bits_q.push_back(sin);
    if (breq && npre == 0)
      early++;
    if (pdone)
      npre++;
    if (act && !act_d)
      sym_q.push_back({si, sq});
    req_d <= breq;
    act_d <= act;
    ext   <= ext_run && !ext;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 16)
    begin
      num_errors++;
      $display("ERROR %0t: bus answer timed out", $time);
      close_out();
    end
  endtask
  task automatic idle_wait();
    int i;
    repeat (8) @(posedge core_clk);
    i = 0;
    do
    begin
      apb(1'b0, btxe_pkg::OFS_STATUS, 32'h0);
      i++;
    end
    while (rd[btxe_pkg::STAT_ACTIVE] !== 1'b0 && i < 400);
    if (i >= 400)
    begin
      num_errors++;
      $display("ERROR %0t: burst did not finish", $time);
      close_out();
    end
  endtask
  task automatic setup_burst(input logic [31:0] len);
    sym_q.delete();
    bits_q.delete();
    npre = 0;
    early = 0;
    apb(1'b1, btxe_pkg::OFS_CHIP_DIV, 32'h1);
    apb(1'b1, btxe_pkg::OFS_DATA_CHIPS, 32'h4);
    apb(1'b1, btxe_pkg::OFS_ACQ_CHIPS, 32'h6);
    apb(1'b1, btxe_pkg::OFS_DCODE_LO, 32'h1);
    apb(1'b1, btxe_pkg::OFS_BURST_LEN, len);
  endtask
  task automatic check_burst(input logic qpsk, input int len);
    logic [1:0] st, d, x;
    logic       e;
    int         k;
    st = 2'h0;
    e = 1'b0;
    chk(sym_q.size(), len + 1);
    chk(bits_q.size(), qpsk ? 2 * len : len);
    chk(npre, 1);
    chk(early, 0);
    chk(sym_q[0], 2'h0);
    for (k = 1; k <= len && k < sym_q.size(); k++)
    begin
      if (qpsk)
      begin
        d = {bits_q[2 * k - 2], bits_q[2 * k - 1]};
        st = st + {d[1], d[1] ^ d[0]};
        x = {st[1], st[1] ^ st[0]};
      end
      else
      begin
        e = e ^ bits_q[k - 1];
        x = {e, e};
      end
      chk(sym_q[k] ^ 2'h3, x);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic regs_test();
    apb(1'b0, btxe_pkg::OFS_CHIP_DIV, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, btxe_pkg::OFS_BURST_LEN, 32'h0);
    chk(rd, 32'h10);
    apb(1'b1, btxe_pkg::OFS_BURST_LEN, 32'h0000FFFF);
    apb(1'b0, btxe_pkg::OFS_BURST_LEN, 32'h0);
    chk(rd, 32'hFFFD);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic bpsk_test();
    setup_burst(32'h3);
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h1);
    @(posedge core_clk);
    start <= 1'b1;
    idle_wait();
    check_burst(1'b0, 3);
  endtask
  task automatic qpsk_test();
    setup_burst(32'h4);
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h5);
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h7);
    idle_wait();
    check_burst(1'b1, 4);
  endtask
  task automatic cont_test();
    logic e;
    int   k;
    setup_burst(32'h1);
    ext_run <= 1'b1;
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h19);
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h1B);
    repeat (300) @(posedge core_clk);
    apb(1'b0, btxe_pkg::OFS_STATUS, 32'h0);
    chk(rd[btxe_pkg::STAT_ACTIVE], 1'b1);
    chk(sym_q.size() > 10, 1'b1);
    chk(npre, 1);
    chk(early, 0);
    chk(sym_q[0], 2'h0);
    e = 1'b0;
    for (k = 1; k <= 8; k++)
    begin
      e = e ^ bits_q[k - 1];
      chk(sym_q[k] ^ 2'h3, {e, e});
    end
    apb(1'b1, btxe_pkg::OFS_CTRL, 32'h0);
    ext_run <= 1'b0;
    apb(1'b0, btxe_pkg::OFS_STATUS, 32'h0);
    chk(rd[btxe_pkg::STAT_ACTIVE], 1'b0);
    chk({act, si, sq}, 3'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    regs_test();
    bpsk_test();
    qpsk_test();
    cont_test();
    close_out();
  end
endmodule // burst_tx_input_diff_encoder_test
